// ===== hw/limit_threshold_alert_regs.sv
// Alert-limit threshold registers, diagnostic flags and alert pin drive.
// Assumes a serial front end on ref_clk issues register reads and writes.
//
// What this block does
// [R1] Memory status bit resets to one, drops to zero on trim checksum error.
// [R2] A negative current high threshold trips overcurrent at zero current.
// [R3] Host sets overcurrent threshold above undercurrent when both negative.
// [R4] Current high threshold: 16-bit signed, read/write, resets 7FFF.
// [R5] Current low threshold: 16-bit signed, read/write, resets 8000.
// [R6] Bus high threshold: bits 14..0 unsigned, resets 7FFF.
// [R7] Bus low threshold: bits 14..0 unsigned, resets zero.
// [R8] Bit 15 of both bus thresholds reads zero, ignores writes.
// [R9] Temp limit: bits 15..4 signed, resets 7FF, compared to die temperature.
// [R10] Temperature threshold bits 3..0 read zero, ignore writes.
// [R11] Power threshold: 16-bit unsigned, 256 power steps each, resets FFFF.
// [R12] Read-only identification register at 3E returns two ASCII characters.
// [R13] Overcurrent flag above high limit, undercurrent flag below low limit.
// [R14] With latch enabled, reading diagnostics clears the limit flags.
// [R15] Polarity zero: active-low alert; one: active-high; both open drain.
// [R16] Each comparison runs whenever its quantity delivers a new result.
`timescale 1ns/100ps
module limit_threshold_alert_regs
  import limit_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [15:0] current_result,
  input wire logic current_valid,
  input wire logic [15:0] bus_voltage_result,
  input wire logic bus_voltage_valid,
  input wire logic [15:0] die_temperature_result,
  input wire logic die_temperature_valid,
  input wire logic [23:0] power_result,
  input wire logic power_valid,
  input wire logic trim_checksum_error,
  output logic alert_o,
  output logic alert_oe_n
);

  limit_cmp_if cmp_bus ();

  // Threshold and control state
  logic [15:0] current_high_threshold;
  logic [15:0] current_low_threshold;
  logic [14:0] bus_voltage_high_threshold;
  logic [14:0] bus_voltage_low_threshold;
  logic [11:0] temperature_high_field;
  logic [15:0] power_high_threshold;
  logic alert_latch_enable;
  logic alert_polarity_select;
  logic trim_memory_ok;
  logic [FLAG_N-1:0] limit_flags;

  logic [15:0] next_current_high_threshold;
  logic [15:0] next_current_low_threshold;
  logic [14:0] next_bus_voltage_high_threshold;
  logic [14:0] next_bus_voltage_low_threshold;
  logic [11:0] next_temperature_high_field;
  logic [15:0] next_power_high_threshold;
  logic next_alert_latch_enable;
  logic next_alert_polarity_select;
  logic next_trim_memory_ok;
  logic [FLAG_N-1:0] next_limit_flags;

  // Read and pin state
  logic [15:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic next_alert_o;
  logic next_alert_oe_n;

  logic diag_read;
  logic [15:0] diag_word;
  logic alert_active;

  // Comparator hookup
  assign cmp_bus.cur_hi = current_high_threshold;
  assign cmp_bus.cur_lo = current_low_threshold;
  assign cmp_bus.bus_hi = bus_voltage_high_threshold;
  assign cmp_bus.bus_lo = bus_voltage_low_threshold;
  assign cmp_bus.temp_hi = temperature_high_field;
  assign cmp_bus.pwr_hi = power_high_threshold;
  assign cmp_bus.cur_res = current_result;
  assign cmp_bus.bus_res = bus_voltage_result;
  assign cmp_bus.temp_res = die_temperature_result;
  assign cmp_bus.pwr_res = power_result;
  assign cmp_bus.cur_v = current_valid;
  assign cmp_bus.bus_v = bus_voltage_valid;
  assign cmp_bus.temp_v = die_temperature_valid;
  assign cmp_bus.pwr_v = power_valid;

  limit_compare u_compare (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .cmp(cmp_bus)
  );

  assign diag_read = reg_rd && (reg_addr == ADDR_DIAG);

  // Diagnostic word
  always_comb begin
    diag_word = 16'h0000;
    diag_word[DIAG_LATCH_BIT] = alert_latch_enable;
    diag_word[DIAG_POLARITY_BIT] = alert_polarity_select;
    diag_word[DIAG_FLAG_LSB +: FLAG_N] = limit_flags;
    diag_word[DIAG_MEM_OK_BIT] = trim_memory_ok;
  end

  // Register writes
  always_comb begin
    next_current_high_threshold = current_high_threshold;
    next_current_low_threshold = current_low_threshold;
    next_bus_voltage_high_threshold = bus_voltage_high_threshold;
    next_bus_voltage_low_threshold = bus_voltage_low_threshold;
    next_temperature_high_field = temperature_high_field;
    next_power_high_threshold = power_high_threshold;
    next_alert_latch_enable = alert_latch_enable;
    next_alert_polarity_select = alert_polarity_select;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_DIAG: begin
          next_alert_latch_enable = reg_wdata[DIAG_LATCH_BIT];
          next_alert_polarity_select = reg_wdata[DIAG_POLARITY_BIT];
        end
        ADDR_CUR_HI: begin
          next_current_high_threshold = reg_wdata; // [R4]
        end
        ADDR_CUR_LO: begin
          next_current_low_threshold = reg_wdata; // [R5]
        end
        ADDR_BUS_HI: begin
          next_bus_voltage_high_threshold = reg_wdata[14:0]; // [R6] [R8]
        end
        ADDR_BUS_LO: begin
          next_bus_voltage_low_threshold = reg_wdata[14:0]; // [R7] [R8]
        end
        ADDR_TEMP_HI: begin
          next_temperature_high_field =
            reg_wdata[15:TEMP_FIELD_LSB]; // [R9] [R10]
        end
        ADDR_PWR_HI: begin
          next_power_high_threshold = reg_wdata; // [R11]
        end
        default: begin
          next_power_high_threshold = power_high_threshold;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      current_high_threshold <= CUR_HI_RST;
      current_low_threshold <= CUR_LO_RST;
      bus_voltage_high_threshold <= BUS_HI_RST;
      bus_voltage_low_threshold <= BUS_LO_RST;
      temperature_high_field <= TEMP_HI_RST;
      power_high_threshold <= PWR_HI_RST;
      alert_latch_enable <= LATCH_RST;
      alert_polarity_select <= POLARITY_RST;
    end else if (ce) begin
      current_high_threshold <= next_current_high_threshold;
      current_low_threshold <= next_current_low_threshold;
      bus_voltage_high_threshold <= next_bus_voltage_high_threshold;
      bus_voltage_low_threshold <= next_bus_voltage_low_threshold;
      temperature_high_field <= next_temperature_high_field;
      power_high_threshold <= next_power_high_threshold;
      alert_latch_enable <= next_alert_latch_enable;
      alert_polarity_select <= next_alert_polarity_select;
    end
  end

  // Trim memory status, sticky low until reset
  always_comb begin
    next_trim_memory_ok = trim_memory_ok && !trim_checksum_error; // [R1]
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trim_memory_ok <= MEM_OK_RST;
    end else if (ce) begin
      trim_memory_ok <= next_trim_memory_ok;
    end
  end

  // Limit flags: a new trip wins over a read clear
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
      assign next_limit_flags[gi] = alert_latch_enable ?
        ((limit_flags[gi] && !diag_read) ||
         (cmp_bus.ev[gi] && cmp_bus.trip[gi])) : // [R14] [R13]
        (cmp_bus.ev[gi] ? cmp_bus.trip[gi] : limit_flags[gi]); // [R13]
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      limit_flags <= '0;
    end else if (ce) begin
      limit_flags <= next_limit_flags;
    end
  end

  // Register reads
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DIAG: next_reg_rdata = diag_word;
        ADDR_CUR_HI: next_reg_rdata = current_high_threshold;
        ADDR_CUR_LO: next_reg_rdata = current_low_threshold;
        ADDR_BUS_HI: begin
          next_reg_rdata = {1'b0, bus_voltage_high_threshold}; // [R8]
        end
        ADDR_BUS_LO: begin
          next_reg_rdata = {1'b0, bus_voltage_low_threshold}; // [R8]
        end
        ADDR_TEMP_HI: begin
          next_reg_rdata = {temperature_high_field, 4'h0}; // [R10]
        end
        ADDR_PWR_HI: next_reg_rdata = power_high_threshold;
        ADDR_MAKER: next_reg_rdata = MAKER_CODE; // [R12]
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // Alert pin: open drain, only ever pulls low
  assign alert_active = |limit_flags;
  always_comb begin
    next_alert_o = 1'b0;
    next_alert_oe_n = alert_polarity_select ?
      alert_active : !alert_active; // [R15]
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      alert_o <= 1'b0;
      alert_oe_n <= 1'b1;
    end else if (ce) begin
      alert_o <= next_alert_o;
      alert_oe_n <= next_alert_oe_n;
    end
  end

endmodule // limit_threshold_alert_regs

// ===== pkg/limit_regs_pkg.sv
// Constants for the alert-limit threshold register bank.
// Assumes an 8-bit register pointer supplied by the serial front end.
package limit_regs_pkg;

  // Register pointer values
  localparam logic [7:0] ADDR_DIAG = 8'h0B;
  localparam logic [7:0] ADDR_CUR_HI = 8'h0C;
  localparam logic [7:0] ADDR_CUR_LO = 8'h0D;
  localparam logic [7:0] ADDR_BUS_HI = 8'h0E;
  localparam logic [7:0] ADDR_BUS_LO = 8'h0F;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h10;
  localparam logic [7:0] ADDR_PWR_HI = 8'h11;
  localparam logic [7:0] ADDR_MAKER = 8'h3E;

  // Reset values
  localparam logic [15:0] CUR_HI_RST = 16'h7FFF;
  localparam logic [15:0] CUR_LO_RST = 16'h8000;
  localparam logic [14:0] BUS_HI_RST = 15'h7FFF;
  localparam logic [14:0] BUS_LO_RST = 15'h0000;
  localparam logic [11:0] TEMP_HI_RST = 12'h07FF;
  localparam logic [15:0] PWR_HI_RST = 16'hFFFF;
  localparam logic MEM_OK_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;
  localparam logic POLARITY_RST = 1'b0;

  // Maker code, two ASCII characters; value is arbitrary
  localparam logic [15:0] MAKER_CODE = 16'h5A5A;

  // Field positions
  localparam int TEMP_FIELD_LSB = 4;
  localparam int PWR_SCALE_SHIFT = 8;
  localparam int DIAG_LATCH_BIT = 15;
  localparam int DIAG_POLARITY_BIT = 12;
  localparam int DIAG_FLAG_LSB = 2;
  localparam int DIAG_MEM_OK_BIT = 0;

  // Limit flag indices; flag i sits at diagnostic bit DIAG_FLAG_LSB + i
  localparam int FLAG_N = 6;
  localparam int FLAG_PWR_HI = 0;
  localparam int FLAG_BUS_LO = 1;
  localparam int FLAG_BUS_HI = 2;
  localparam int FLAG_CUR_LO = 3;
  localparam int FLAG_CUR_HI = 4;
  localparam int FLAG_TEMP_HI = 5;

endpackage

// ===== pkg/limit_cmp_if.sv
// Carries thresholds and results to the comparator, and trips back.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface limit_cmp_if;
  import limit_regs_pkg::*;
  logic [15:0] cur_hi;
  logic [15:0] cur_lo;
  logic [14:0] bus_hi;
  logic [14:0] bus_lo;
  logic [11:0] temp_hi;
  logic [15:0] pwr_hi;
  logic [15:0] cur_res;
  logic [15:0] bus_res;
  logic [15:0] temp_res;
  logic [23:0] pwr_res;
  logic cur_v;
  logic bus_v;
  logic temp_v;
  logic pwr_v;
  logic [FLAG_N-1:0] ev;
  logic [FLAG_N-1:0] trip;

  modport regs (
    output cur_hi, cur_lo, bus_hi, bus_lo, temp_hi, pwr_hi,
    output cur_res, bus_res, temp_res, pwr_res,
    output cur_v, bus_v, temp_v, pwr_v,
    input ev, trip
  );
  modport cmp (
    input cur_hi, cur_lo, bus_hi, bus_lo, temp_hi, pwr_hi,
    input cur_res, bus_res, temp_res, pwr_res,
    input cur_v, bus_v, temp_v, pwr_v,
    output ev, trip
  );
endinterface // limit_cmp_if

// ===== hw/limit_compare.sv
// Compares each new conversion result with its thresholds.
// Assumes results and strobes come from logic on ref_clk.
`timescale 1ns/100ps
module limit_compare
  import limit_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  limit_cmp_if.cmp cmp
);

  logic [FLAG_N-1:0] ev;
  logic [FLAG_N-1:0] trip;
  logic [FLAG_N-1:0] next_ev;
  logic [FLAG_N-1:0] next_trip;

  always_comb begin
    next_ev = '0;
    next_trip = trip;
    if (cmp.cur_v) begin // [R16]
      next_ev[FLAG_CUR_HI] = 1'b1;
      next_ev[FLAG_CUR_LO] = 1'b1;
      // Signed compare: a negative high limit trips already at zero
      next_trip[FLAG_CUR_HI] =
        $signed(cmp.cur_res) > $signed(cmp.cur_hi); // [R2] [R4] [R13]
      next_trip[FLAG_CUR_LO] =
        $signed(cmp.cur_res) < $signed(cmp.cur_lo); // [R5] [R13]
    end
    if (cmp.bus_v) begin // [R16]
      next_ev[FLAG_BUS_HI] = 1'b1;
      next_ev[FLAG_BUS_LO] = 1'b1;
      next_trip[FLAG_BUS_HI] = cmp.bus_res > {1'b0, cmp.bus_hi}; // [R6]
      next_trip[FLAG_BUS_LO] = cmp.bus_res < {1'b0, cmp.bus_lo}; // [R7]
    end
    if (cmp.temp_v) begin // [R16]
      next_ev[FLAG_TEMP_HI] = 1'b1;
      next_trip[FLAG_TEMP_HI] =
        $signed(cmp.temp_res[15:TEMP_FIELD_LSB]) >
        $signed(cmp.temp_hi); // [R9]
    end
    if (cmp.pwr_v) begin // [R16]
      next_ev[FLAG_PWR_HI] = 1'b1;
      next_trip[FLAG_PWR_HI] =
        cmp.pwr_res > {cmp.pwr_hi, {PWR_SCALE_SHIFT{1'b0}}}; // [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ev <= '0;
      trip <= '0;
    end else if (ce) begin
      ev <= next_ev;
      trip <= next_trip;
    end
  end

  assign cmp.ev = ev;
  assign cmp.trip = trip;

endmodule // limit_compare

// ===== test/limit_regs_monitor.sv
// Port checker for the alert-limit register bank.
// Assumes bind to the top module; one clock, ce mostly high.
`timescale 1ns/100ps
module limit_regs_monitor
  import limit_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic trim_checksum_error,
  input wire logic alert_o,
  input wire logic alert_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic mem_err;
  logic next_mem_err;
  always_comb next_mem_err = mem_err | (ce & trim_checksum_error);
  always_ff @(posedge ref_clk) begin
    if (!rstn) mem_err <= 1'b0;
    else mem_err <= next_mem_err;
  end
  sequence rd_at(a);
    ce && reg_rd && reg_addr == a;
  endsequence
  AST_RVALID: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_IDLE: assert property (ce && !reg_rd |=> !reg_rvalid &&
    reg_rdata == 16'h0000) else $error("answer without read");
  AST_MAKER: assert property (rd_at(ADDR_MAKER) |=>
    reg_rdata == MAKER_CODE) else $error("maker code wrong");
  AST_BUS_RSV: assert property (ce && reg_rd &&
    reg_addr[7:1] == 7'h07 |=> !reg_rdata[15]) else $error("bus bit 15 set");
  AST_TEMP_RSV: assert property (rd_at(ADDR_TEMP_HI) |=>
    reg_rdata[3:0] == 4'h0) else $error("temp low bits set");
  AST_MEM: assert property (rd_at(ADDR_DIAG) |=>
    reg_rdata[0] == !$past(mem_err)) else $error("memory status wrong");
  AST_ALERT_POLARITY: assert property (rd_at(ADDR_DIAG) |=>
    alert_oe_n == ((|reg_rdata[7:2]) == reg_rdata[12]))
    else $error("alert drive disagrees with flags");
  AST_OE_RST: assert property ($rose(rstn) |-> alert_oe_n)
    else $error("alert driven after reset");
  AST_ALERT_LOW: assert property (alert_o == 1'b0)
    else $error("alert pull value not low");
endmodule // limit_regs_monitor

// ===== test/reg_host_model.sv
// Register host: one-cycle read and write strobes.
// Assumes the bench calls its tasks; changes land at falling edges.
`timescale 1ns/100ps
module reg_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  task automatic wr(logic [7:0] a, logic [15:0] dt);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, dt, 1'b1};
    @(negedge ref_clk);
    // Released lines carry inverted junk
    {reg_addr, reg_wdata, reg_wr} = {~a, ~dt, 1'b0};
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] dt, output logic vl);
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    dt = reg_rdata;
    vl = reg_rvalid;
  endtask
endmodule // reg_host_model

// ===== test/tb.sv
// Self-checking bench for the alert-limit register bank.
// Assumes host model and checker compiled first; ce held high except in the clock_enable test.
`timescale 1ns/100ps
module tb;
  import limit_regs_pkg::*;
  logic ref_clk, rstn, ce, reg_wr, reg_rd, reg_rvalid, v;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, current_result, bus_voltage_result;
  logic [15:0] die_temperature_result, ch, cl, bh, bl, th, ph, d, m, rc, rb;
  logic [15:0] rt;
  logic [23:0] power_result, rp;
  logic current_valid, bus_voltage_valid, die_temperature_valid;
  logic power_valid, trim_checksum_error, alert_o, alert_oe_n;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 62;
  limit_threshold_alert_regs DUT (.ref_clk, .rstn, .ce, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .current_result,
    .current_valid, .bus_voltage_result, .bus_voltage_valid,
    .die_temperature_result, .die_temperature_valid, .power_result,
    .power_valid, .trim_checksum_error, .alert_o, .alert_oe_n);
  reg_host_model u_host (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(logic [7:0] a, logic [15:0] e);
    u_host.rd(a, d, v);
    chk("read valid", 16'h0001, {15'h0000, v});
    chk($sformatf("register %h", a), e, d);
  endtask
  task automatic do_reset;
    @(negedge ref_clk) rstn = 1'b0;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
  endtask
  task automatic pulse(logic [3:0] mk, logic [15:0] c, b, t, logic [23:0] p);
    @(negedge ref_clk);
    {current_result, bus_voltage_result, die_temperature_result} = {c, b, t};
    power_result = p;
    {current_valid, bus_voltage_valid, die_temperature_valid} = mk[3:1];
    power_valid = mk[0];
    @(negedge ref_clk);
    {current_valid, bus_voltage_valid, die_temperature_valid} = 3'h0;
    power_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  function automatic logic [15:0] exp_flags(logic [15:0] c, b, t,
      logic [23:0] p);
    return {8'h00, $signed(t[15:4]) > $signed(th[15:4]),
      $signed(c) > $signed(ch), $signed(c) < $signed(cl),
      b > {1'b0, bh[14:0]}, b < {1'b0, bl[14:0]}, p > {ph, 8'h00}, 2'b01};
  endfunction
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done;
  end
  initial begin
    {rstn, ce, trim_checksum_error} = 3'b010;
    {current_valid, bus_voltage_valid, die_temperature_valid} = 3'h0;
    power_valid = 1'b0;
    {current_result, bus_voltage_result, die_temperature_result} = '0;
    power_result = '0;
    do_reset;
    rd_chk(ADDR_CUR_HI, 16'h7FFF);
    rd_chk(ADDR_CUR_LO, 16'h8000);
    rd_chk(ADDR_BUS_HI, 16'h7FFF);
    rd_chk(ADDR_BUS_LO, 16'h0000);
    rd_chk(ADDR_TEMP_HI, 16'h7FF0);
    rd_chk(ADDR_PWR_HI, 16'hFFFF);
    rd_chk(ADDR_DIAG, 16'h0001);
    rd_chk(8'h20, 16'h0000);
    $display("test reset_values done");
    for (int i = 0; i < 24; i++) begin
      {ch, cl} = $random(seed);
      {bh, bl} = $random(seed);
      {th, ph} = $random(seed);
      {rc, rb} = $random(seed);
      {rt, rp[23:8]} = $random(seed);
      rp[7:0] = rt[7:0];
      if (i == 0) {ch, cl, rc} = {16'hFFFF, 16'h8000, 16'h0000};
      if ($signed(ch) < $signed(cl)) {ch, cl} = {cl, ch};
      if (i == 1) {rc, rp} = {ch, ph, 8'h00};
      u_host.wr(ADDR_CUR_HI, ch);
      u_host.wr(ADDR_CUR_LO, cl);
      u_host.wr(ADDR_BUS_HI, bh);
      u_host.wr(ADDR_BUS_LO, bl);
      u_host.wr(ADDR_TEMP_HI, th);
      u_host.wr(ADDR_PWR_HI, ph);
      u_host.wr(ADDR_MAKER, ch);
      rd_chk(ADDR_CUR_HI, ch);
      rd_chk(ADDR_CUR_LO, cl);
      rd_chk(ADDR_BUS_HI, bh & 16'h7FFF);
      rd_chk(ADDR_BUS_LO, bl & 16'h7FFF);
      rd_chk(ADDR_TEMP_HI, th & 16'hFFF0);
      rd_chk(ADDR_PWR_HI, ph);
      rd_chk(ADDR_MAKER, MAKER_CODE);
      pulse(4'hF, rc, rb, rt, rp);
      m = exp_flags(rc, rb, rt, rp);
      rd_chk(ADDR_DIAG, m);
      chk("alert_oe_n", {15'h0000, ~|m[7:2]}, {15'h0000, alert_oe_n});
    end
    $display("test random_limits done");
    u_host.wr(ADDR_DIAG, 16'h8000);
    u_host.rd(ADDR_DIAG, d, v);
    u_host.wr(ADDR_CUR_HI, 16'h0000);
    u_host.wr(ADDR_CUR_LO, 16'h8000);
    pulse(4'h8, 16'h0001, rb, rt, rp);
    pulse(4'h8, 16'h0000, rb, rt, rp);
    rd_chk(ADDR_DIAG, 16'h8041);
    rd_chk(ADDR_DIAG, 16'h8001);
    u_host.wr(ADDR_DIAG, 16'h9000);
    rd_chk(ADDR_DIAG, 16'h9001);
    chk("alert_oe_n", 16'h0000, {15'h0000, alert_oe_n});
    $display("test latch_polarity done");
    u_host.wr(ADDR_DIAG, 16'h0000);
    @(negedge ref_clk) trim_checksum_error = 1'b1;
    @(negedge ref_clk) trim_checksum_error = 1'b0;
    u_host.rd(ADDR_DIAG, d, v);
    chk("trim_memory_ok", 16'h0000, {15'h0000, d[0]});
    do_reset;
    rd_chk(ADDR_DIAG, 16'h0001);
    rd_chk(ADDR_CUR_HI, 16'h7FFF);
    $display("test trim_reset done");
    @(negedge ref_clk) ce = 1'b0;
    u_host.wr(ADDR_CUR_HI, 16'h1234);
    u_host.rd(ADDR_CUR_HI, d, v);
    @(negedge ref_clk) trim_checksum_error = 1'b1;
    @(negedge ref_clk) {ce, trim_checksum_error} = 2'b10;
    chk("frozen read valid", 16'h0000, {15'h0000, v});
    rd_chk(ADDR_CUR_HI, 16'h7FFF);
    rd_chk(ADDR_DIAG, 16'h0001);
    $display("test clock_enable done");
    test_done;
  end
endmodule // tb
bind limit_threshold_alert_regs limit_regs_monitor u_mon (.ref_clk, .rstn,
  .ce, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .trim_checksum_error,
  .alert_o, .alert_oe_n);
